// File: core/adc_start_power_mux_control.sv
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module adc_start_power_mux_control #(
	parameter int CAL_TICKS = conv_ctrl_pkg::CAL_TICKS_DEF,
	parameter int CONV_CLK_DIV = conv_ctrl_pkg::CONV_CLK_DIV_DEF
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [conv_ctrl_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Converter side
	input wire logic [conv_ctrl_pkg::NUM_CONV-1:0] conv_done,
	output logic [conv_ctrl_pkg::NUM_CONV-1:0] converter_go,
	output logic [conv_ctrl_pkg::NUM_CONV-1:0] single_converter_reset,
	output logic [conv_ctrl_pkg::NUM_CONV-1:0] single_converter_power_down,
	output logic [conv_ctrl_pkg::NUM_CONV*conv_ctrl_pkg::MUX_W-1:0] input_mux_select,
	output logic [conv_ctrl_pkg::NUM_CONV-1:0] conv_calibrating,
	// Sequencer side
	output logic [conv_ctrl_pkg::NUM_CONV-1:0] seq_stall,
	// Analog block
	output logic reference_select,
	output logic analog_block_power_on,
	output logic analog_ctrl_block_reset
);
	localparam int N = conv_ctrl_pkg::NUM_CONV;
	localparam int DW = $clog2(CONV_CLK_DIV + 1);
	localparam logic [DW-1:0] DIV_LAST = DW'(CONV_CLK_DIV - 1);

	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	logic [7:0] sync_q, sync_d;
	logic [7:0] comm_q, comm_d;
	logic [7:0] conv_q [N];
	logic [7:0] conv_d [N];
	logic [7:0] misc_q [N];
	logic [7:0] misc_d [N];
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d;
	logic pslverr_q, pslverr_d;
	logic [DW-1:0] div_q, div_d;
	logic tick_q, tick_d;
	logic wr_en;
	logic rd_phase;
	logic hit;
	logic [31:0] rdata;
	logic [N-1:0] stall_v;
	logic [N-1:0] cal_v;

	conv_lane_if lane_bus [N] ();

	function automatic logic [11:0] lane_addr(input logic [11:0] base, input int idx);
		lane_addr = base + conv_ctrl_pkg::LANE_STRIDE * 12'(idx);
	endfunction

	// ------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------
	// One wait state keeps every bus output registered
	assign rd_phase = psel && penable && !pready_q;
	assign wr_en = psel && penable && pready_q && pwrite && !pslverr_q;

	always_comb begin
		hit = 1'b0;
		rdata = 32'h0000_0000;
		if (paddr == conv_ctrl_pkg::SYNC_OFF) begin
			hit = 1'b1;
			rdata = {24'h000000, sync_q};
		end
		if (paddr == conv_ctrl_pkg::COMM_OFF) begin
			hit = 1'b1;
			// Block reset trigger is write-only
			rdata = {24'h000000, comm_q & ~(8'h01 << conv_ctrl_pkg::COMM_ACB_RST)};
		end
		if (paddr == conv_ctrl_pkg::STATUS_OFF) begin
			hit = 1'b1;
			rdata = {24'h000000, 1'b0, cal_v, 1'b0, stall_v};
		end
		for (int i = 0; i < N; i++) begin
			if (paddr == lane_addr(conv_ctrl_pkg::CONV0_OFF, i)) begin
				hit = 1'b1;
				// Wait bit is write-only
				rdata = {24'h000000, conv_q[i] & ~(8'h01 << conv_ctrl_pkg::CONV_STALL)};
			end
			if (paddr == lane_addr(conv_ctrl_pkg::MISC0_OFF, i)) begin
				hit = 1'b1;
				rdata = {24'h000000, misc_q[i]};
			end
		end
	end

	always_comb begin
		pready_d = 1'b0;
		pslverr_d = 1'b0;
		prdata_d = prdata_q;
		if (rd_phase) begin
			pready_d = 1'b1;
			pslverr_d = !hit;
			prdata_d = (pwrite || !hit) ? 32'h0000_0000 : rdata;
		end
	end

	// ------------------------------------------------------------
	// Register updates
	// ------------------------------------------------------------
	always_comb begin
		// Trigger bits hold for one cycle only
		sync_d = sync_q & 8'hF8; // RULE_02
		comm_d = comm_q & ~((8'h01 << conv_ctrl_pkg::COMM_ACB_RST)
			| (8'h01 << conv_ctrl_pkg::COMM_ALL_RST)); // RULE_05 RULE_08
		for (int i = 0; i < N; i++) begin
			conv_d[i] = conv_q[i] & ~(8'h01 << conv_ctrl_pkg::CONV_GO); // RULE_10
			misc_d[i] = misc_q[i] & ~(8'h01 << conv_ctrl_pkg::MISC_RST); // RULE_14
		end
		if (wr_en) begin
			// Reserved bits are stored as written
			if (paddr == conv_ctrl_pkg::SYNC_OFF) begin
				sync_d = pwdata[7:0]; // RULE_01 RULE_13
			end
			if (paddr == conv_ctrl_pkg::COMM_OFF) begin
				comm_d = pwdata[7:0];
			end
			for (int i = 0; i < N; i++) begin
				if (paddr == lane_addr(conv_ctrl_pkg::CONV0_OFF, i)) begin
					conv_d[i] = pwdata[7:0];
				end
				if (paddr == lane_addr(conv_ctrl_pkg::MISC0_OFF, i)) begin
					misc_d[i] = pwdata[7:0];
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Converter clock enable
	// ------------------------------------------------------------
	always_comb begin
		tick_d = (div_q == DIV_LAST);
		div_d = tick_d ? DW'(0) : div_q + DW'(1);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_q <= conv_ctrl_pkg::SYNC_RESET;
			comm_q <= conv_ctrl_pkg::COMM_RESET; // RULE_09
			for (int i = 0; i < N; i++) begin
				conv_q[i] <= conv_ctrl_pkg::CONV_RESET;
				misc_q[i] <= conv_ctrl_pkg::MISC_RESET;
			end
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			div_q <= '0;
			tick_q <= 1'b0;
		end else begin
			sync_q <= sync_d;
			comm_q <= comm_d;
			for (int i = 0; i < N; i++) begin
				conv_q[i] <= conv_d[i];
				misc_q[i] <= misc_d[i];
			end
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			div_q <= div_d;
			tick_q <= tick_d;
		end
	end

	// ------------------------------------------------------------
	// Per-converter lanes
	// ------------------------------------------------------------
	for (genvar g = 0; g < N; g++) begin : lane
		logic sync_go;
		logic one_go;

		assign sync_go = sync_d[conv_ctrl_pkg::SYNC_GO_LSB + g]; // RULE_01
		assign one_go = conv_d[g][conv_ctrl_pkg::CONV_GO]; // RULE_10
		// Both sources merge into one pulse
		assign lane_bus[g].go_req = sync_go | one_go; // RULE_17
		// Stall only when the start that fires asks for it
		assign lane_bus[g].stall_req =
			(sync_go & sync_d[conv_ctrl_pkg::SYNC_STALL_LSB + g])
			| (one_go & conv_d[g][conv_ctrl_pkg::CONV_STALL]); // RULE_03 RULE_04 RULE_11
		assign lane_bus[g].reset_req = comm_d[conv_ctrl_pkg::COMM_ALL_RST]
			| misc_d[g][conv_ctrl_pkg::MISC_RST]; // RULE_08 RULE_14
		assign lane_bus[g].pd_req = comm_d[conv_ctrl_pkg::COMM_ALL_PD]
			| misc_d[g][conv_ctrl_pkg::MISC_PD]; // RULE_07 RULE_15
		assign lane_bus[g].tick = tick_q;
		assign lane_bus[g].done = conv_done[g];

		converter_lane #(
			.CAL_TICKS(CAL_TICKS)
		) u_lane (
			.pclk(pclk),
			.presetn(presetn),
			.bus(lane_bus[g])
		);

		assign converter_go[g] = lane_bus[g].go;
		assign single_converter_reset[g] = lane_bus[g].rst;
		assign single_converter_power_down[g] = lane_bus[g].pd;
		assign stall_v[g] = lane_bus[g].stall;
		assign cal_v[g] = lane_bus[g].cal;
		assign input_mux_select[g*conv_ctrl_pkg::MUX_W +: conv_ctrl_pkg::MUX_W] =
			conv_q[g][conv_ctrl_pkg::MUX_LSB +: conv_ctrl_pkg::MUX_W]; // RULE_12
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign seq_stall = stall_v;
	assign conv_calibrating = cal_v;
	assign reference_select = comm_q[conv_ctrl_pkg::COMM_REF_SEL]; // RULE_09
	assign analog_block_power_on = comm_q[conv_ctrl_pkg::COMM_PWR_ON]; // RULE_06
	assign analog_ctrl_block_reset = comm_q[conv_ctrl_pkg::COMM_ACB_RST]; // RULE_05
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
endmodule
`default_nettype wire

// File: core/conv_ctrl_pkg.sv
// Summary of operation
// [RULE_01] Writing 1 to a synchronized start bit 0..2 starts that converter; 0 does nothing.
// [RULE_02] Start and reset-trigger bits self-clear one clock after a write of 1.
// [RULE_03] Synchronized wait bit 1: sequencer advances once, then stalls until conversion done.
// [RULE_04] Synchronized wait bit 0: sequencer keeps advancing without waiting.
// [RULE_05] Common bit 4 write-only: 1 resets analog control block, self-clears.
// [RULE_06] Common bit 3 powers whole analog block on (1) or down (0).
// [RULE_07] Common bit 2 powers down all converters, ORed with each own power-down bit.
// [RULE_08] Common bit 1 resets all converters, self-clears, ORed with each own reset.
// [RULE_09] Common bit 0 selects external (1) or internal (0) reference; resets to 1.
// [RULE_10] Per-converter bit 7 starts that converter; self-clears after one clock.
// [RULE_11] Per-converter write-only wait bit 6 makes that sequencer stall after a start.
// [RULE_12] Per-converter bits 3:0 select one of 16 multiplexer inputs.
// [RULE_13] Software preserves reserved bits; device stores them read/write, reset 0.
// [RULE_14] Each converter's own reset bit 4 self-clears one clock after a write.
// [RULE_15] Each converter's own power-down bit 5 requests power-down of that converter.
// [RULE_16] After reset release a converter calibrates for 3840 converter clock cycles.
// [RULE_17] Simultaneous synchronized and per-converter start give exactly one start pulse.
package conv_ctrl_pkg;
	localparam int NUM_CONV = 3;
	localparam int ADDR_W = 12;
	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [11:0] SYNC_OFF = 12'h008;
	localparam logic [11:0] COMM_OFF = 12'h00C;
	localparam logic [11:0] CONV0_OFF = 12'h050;
	localparam logic [11:0] MISC0_OFF = 12'h05C;
	localparam logic [11:0] LANE_STRIDE = 12'h040;
	localparam logic [11:0] STATUS_OFF = 12'h0E0;
	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int SYNC_GO_LSB = 0;
	localparam int SYNC_STALL_LSB = 4;
	localparam int COMM_REF_SEL = 0;
	localparam int COMM_ALL_RST = 1;
	localparam int COMM_ALL_PD = 2;
	localparam int COMM_PWR_ON = 3;
	localparam int COMM_ACB_RST = 4;
	localparam int CONV_GO = 7;
	localparam int CONV_STALL = 6;
	localparam int MUX_LSB = 0;
	localparam int MUX_W = 4;
	localparam int MISC_RST = 4;
	localparam int MISC_PD = 5;
	localparam int STAT_STALL_LSB = 0;
	localparam int STAT_CAL_LSB = 4;
	// ------------------------------------------------------------
	// Reset values and timing
	// ------------------------------------------------------------
	localparam logic [7:0] SYNC_RESET = 8'h00;
	localparam logic [7:0] COMM_RESET = 8'h01;
	localparam logic [7:0] CONV_RESET = 8'h00;
	localparam logic [7:0] MISC_RESET = 8'h00;
	localparam int CAL_TICKS_DEF = 3840;
	localparam int CONV_CLK_DIV_DEF = 4;
endpackage

// File: core/conv_lane_if.sv
`timescale 1ns/100ps
`default_nettype none
interface conv_lane_if;
	logic go_req;
	logic stall_req;
	logic reset_req;
	logic pd_req;
	logic tick;
	logic done;
	logic go;
	logic stall;
	logic rst;
	logic pd;
	logic cal;
	modport ctrl(output go_req, stall_req, reset_req, pd_req, tick, done,
		input go, stall, rst, pd, cal);
	modport lane(input go_req, stall_req, reset_req, pd_req, tick, done,
		output go, stall, rst, pd, cal);
endinterface
`default_nettype wire

// File: core/converter_lane.sv
`timescale 1ns/100ps
`default_nettype none
module converter_lane #(
	parameter int CAL_TICKS = conv_ctrl_pkg::CAL_TICKS_DEF
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Control side
	conv_lane_if.lane bus
);
	localparam int CW = $clog2(CAL_TICKS + 1);
	localparam logic [CW-1:0] CAL_LOAD = CW'(CAL_TICKS);

	logic go_q, go_d;
	logic stall_q, stall_d;
	logic rst_q, rst_d;
	logic pd_q, pd_d;
	logic cal_q, cal_d;
	logic [CW-1:0] cnt_q, cnt_d;

	always_comb begin
		go_d = bus.go_req; // RULE_17
		rst_d = bus.reset_req;
		pd_d = bus.pd_req;
		stall_d = stall_q;
		if (bus.done) begin
			stall_d = 1'b0;
		end
		// New stalling start wins over a completion in the same cycle
		if (bus.go_req && bus.stall_req) begin
			stall_d = 1'b1; // RULE_03
		end
		cal_d = cal_q;
		cnt_d = cnt_q;
		if (rst_q) begin
			cal_d = 1'b1;
			cnt_d = CAL_LOAD;
		end else if (cal_q && bus.tick) begin
			cnt_d = cnt_q - CW'(1); // RULE_16
			if (cnt_q == CW'(1)) begin
				cal_d = 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			go_q <= 1'b0;
			stall_q <= 1'b0;
			rst_q <= 1'b0;
			pd_q <= 1'b0;
			cal_q <= 1'b1;
			cnt_q <= CAL_LOAD;
		end else begin
			go_q <= go_d;
			stall_q <= stall_d;
			rst_q <= rst_d;
			pd_q <= pd_d;
			cal_q <= cal_d;
			cnt_q <= cnt_d;
		end
	end

	assign bus.go = go_q;
	assign bus.stall = stall_q;
	assign bus.rst = rst_q;
	assign bus.pd = pd_q;
	assign bus.cal = cal_q;
endmodule
`default_nettype wire

// File: verif/adc_ctrl_sva.sv
`timescale 1ns/100ps
`default_nettype none
module adc_ctrl_sva #(
	parameter int CAL_TICKS = 3840,
	parameter int CONV_CLK_DIV = 4
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic pready,
	input wire logic pslverr,
	// Converter and sequencer side
	input wire logic [2:0] conv_done,
	input wire logic [2:0] converter_go,
	input wire logic [2:0] single_converter_reset,
	input wire logic [2:0] single_converter_power_down,
	input wire logic [11:0] input_mux_select,
	input wire logic [2:0] seq_stall,
	// Analog block
	input wire logic reference_select,
	input wire logic analog_block_power_on,
	input wire logic analog_ctrl_block_reset
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	a_go_cause: assert property (converter_go != 3'h0 |-> $past(pready && pwrite && !pslverr))
		else $error("start pulse without a completed write");
	a_go_pulse: assert property (converter_go != 3'h0 |=> converter_go == 3'h0)
		else $error("start pulse longer than one cycle");
	a_acb_pulse: assert property (analog_ctrl_block_reset |=> !analog_ctrl_block_reset)
		else $error("analog block reset longer than one cycle");
	a_rst_pulse: assert property (single_converter_reset != 3'h0 |=> single_converter_reset == 3'h0)
		else $error("converter reset longer than one cycle");
	a_stall_rise: assert property (((seq_stall & ~$past(seq_stall)) & ~converter_go) == 3'h0)
		else $error("stall rose without a start");
	a_stall_fall: assert property (((~seq_stall & $past(seq_stall)) & ~$past(conv_done)) == 3'h0)
		else $error("stall dropped before conversion done");
	a_level_hold: assert property (!$past(pready && pwrite) |-> $stable({single_converter_power_down,
		input_mux_select, reference_select, analog_block_power_on}))
		else $error("control level changed without a write");
	a_access_two: assert property ($rose(penable) && psel |-> !pready ##1 pready)
		else $error("access phase not two cycles");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("slave error without ready");
	cover property (converter_go != 3'h0 && seq_stall != 3'h0);
	cover property (single_converter_reset != 3'h0);
	cover property (pslverr);
endmodule
bind adc_start_power_mux_control adc_ctrl_sva #(.CAL_TICKS(CAL_TICKS), .CONV_CLK_DIV(CONV_CLK_DIV))
	chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.pready(pready), .pslverr(pslverr), .conv_done(conv_done), .converter_go(converter_go),
	.single_converter_reset(single_converter_reset), .input_mux_select(input_mux_select),
	.single_converter_power_down(single_converter_power_down), .seq_stall(seq_stall),
	.reference_select(reference_select), .analog_block_power_on(analog_block_power_on),
	.analog_ctrl_block_reset(analog_ctrl_block_reset));
`default_nettype wire

// File: verif/adc_start_power_mux_control_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module adc_start_power_mux_control_tb_top;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slow, err;
	logic ref_sel, pwr_on, acb_rst;
	logic [11:0] paddr, mux, off;
	logic [31:0] pwdata, prdata, rd;
	logic [2:0] done, go, srst, spd, cal, stall;
	logic [3:0] m;
	int bad_count, checked;
	adc_start_power_mux_control #(.CAL_TICKS(5), .CONV_CLK_DIV(2)) uut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .conv_done(done),
		.converter_go(go), .single_converter_reset(srst), .single_converter_power_down(spd),
		.input_mux_select(mux), .conv_calibrating(cal), .seq_stall(stall),
		.reference_select(ref_sel), .analog_block_power_on(pwr_on),
		.analog_ctrl_block_reset(acb_rst));
	converter_model far (.pclk(pclk), .presetn(presetn), .converter_go(go), .slow(slow),
		.conv_done(done));
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic report_and_stop;
		$display("checked %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			bad_count++;
			report_and_stop();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle cycle, so two calls never drive psel twice in one step
		@(posedge pclk);
	endtask
	// Leaves the caller at the edge that samples the pulse cycle
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus(a, 1'b1, d);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		bus(a, 1'b0, 32'h0);
		check("read", rd, exp);
		check("err", err, 1'h0);
	endtask
	task automatic wait_free;
		int n;
		n = 0;
		while (stall !== 3'h0 && n < 40) begin
			@(posedge pclk);
			n++;
		end
		if (stall !== 3'h0) begin
			bad_count++;
			report_and_stop();
		end
	endtask
	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	initial begin
		{presetn, psel, penable, pwrite, slow} = 5'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		check("ref", ref_sel, 1'h1);
		check("cal", cal, 3'h7);
		rdc(conv_ctrl_pkg::STATUS_OFF, 32'h70);
		rdc(conv_ctrl_pkg::COMM_OFF, 32'h01);
		rdc(conv_ctrl_pkg::SYNC_OFF, 32'h00);
		wr(conv_ctrl_pkg::COMM_OFF, 32'hEE);
		check("srst", srst, 3'h7);
		check("spd", spd, 3'h7);
		check("pwr", pwr_on, 1'h1);
		check("ref", ref_sel, 1'h0);
		@(posedge pclk);
		check("srst", srst, 3'h0);
		rdc(conv_ctrl_pkg::COMM_OFF, 32'hEC);
		wr(conv_ctrl_pkg::COMM_OFF, 32'h11);
		check("acb", acb_rst, 1'h1);
		check("spd", spd, 3'h0);
		@(posedge pclk);
		check("acb", acb_rst, 1'h0);
		rdc(conv_ctrl_pkg::COMM_OFF, 32'h01);
		$display("test common done");
		for (int i = 0; i < 3; i++) begin
			off = 12'(i) * conv_ctrl_pkg::LANE_STRIDE;
			m = 4'(15 * i / 2);
			slow <= i[0];
			wr(conv_ctrl_pkg::MISC0_OFF + off, 32'h20);
			check("spd", spd, 3'h1 << i);
			wr(conv_ctrl_pkg::MISC0_OFF + off, 32'h10);
			check("srst", srst, 3'h1 << i);
			check("spd", spd, 3'h0);
			@(posedge pclk);
			check("srst", srst, 3'h0);
			check("cal", cal[i], 1'h1);
			wr(conv_ctrl_pkg::SYNC_OFF, 32'h11 << i);
			check("go", go, 3'h1 << i);
			check("stall", stall, 3'h1 << i);
			wait_free();
			wr(conv_ctrl_pkg::SYNC_OFF, 32'h01 << i);
			check("go", go, 3'h1 << i);
			check("stall", stall, 3'h0);
			wr(conv_ctrl_pkg::SYNC_OFF, 32'h00);
			check("go", go, 3'h0);
			wr(conv_ctrl_pkg::CONV0_OFF + off, {24'h0, 4'hC, m});
			check("go", go, 3'h1 << i);
			check("stall", stall, 3'h1 << i);
			check("mux", mux[4*i +: 4], m);
			wait_free();
			rdc(conv_ctrl_pkg::CONV0_OFF + off, {28'h0, m});
			wr(conv_ctrl_pkg::CONV0_OFF + off, {24'h0, 4'h3, m});
			check("stall", stall, 3'h0);
			rdc(conv_ctrl_pkg::CONV0_OFF + off, {24'h0, 4'h3, m});
		end
		$display("test lanes done");
		check("cal", cal, 3'h0);
		bus(12'h004, 1'b0, 32'h0);
		check("err", err, 1'h1);
		check("rdata", rd, 32'h0);
		$display("test unmapped done");
		report_and_stop();
	end
endmodule
`default_nettype wire

// File: verif/converter_model.sv
`timescale 1ns/100ps
`default_nettype none
module converter_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Converter side
	input wire logic [2:0] converter_go,
	input wire logic slow,
	output logic [2:0] conv_done
);
	// ------------------------------------------------------------
	// Conversion timers, a new start restarts the count
	// ------------------------------------------------------------
	logic [3:0] left_q [3];
	logic [3:0] left_d [3];
	logic [2:0] done_d;
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			left_d[i] = (left_q[i] != 4'h0) ? left_q[i] - 4'h1 : 4'h0;
			done_d[i] = (left_q[i] == 4'h1);
			if (converter_go[i]) left_d[i] = slow ? 4'hC : 4'h3;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			left_q <= '{default: 4'h0};
			conv_done <= 3'h0;
		end else begin
			left_q <= left_d;
			conv_done <= done_d;
		end
	end
endmodule
`default_nettype wire
